/* rtl/reset_seq_defines.vh */
`ifndef RESET_SEQ_DEFINES_VH
`define RESET_SEQ_DEFINES_VH

// register map, byte address of an 8-bit register, one register per 4-byte word (address = 4 * index)
`define ADDR_W 8
`define OFF_IRQ_FLAG0 8'h00
`define OFF_IRQ_FLAG1 8'h04
`define OFF_IRQ_FLAG2 8'h08
`define OFF_IRQ_MASK0 8'h0c
`define OFF_IRQ_MASK1 8'h10
`define OFF_IRQ_MASK2 8'h14
`define OFF_EDGE_MODE_A 8'h18
`define OFF_EDGE_MODE_B 8'h1c
`define OFF_SUBCLK_SEL 8'h20
`define OFF_PSW 8'h24
`define OFF_OSC_SETTLE 8'h28
`define OFF_STATUS 8'h2c
`define OFF_PC_LO 8'h30
`define OFF_PC_HI 8'h34

// reset values
`define RST_IRQ_FLAG 8'h00
`define RST_IRQ_MASK 8'hff
`define RST_EDGE_MODE 8'h00
`define RST_SUBCLK_SEL 8'h00
`define RST_PSW 8'h02
`define RST_OSC_SETTLE 8'h04

// reset vector table entries
`define VEC_LO_ADDR 16'h0000
`define VEC_HI_ADDR 16'h0001

// settle wait after reset, as a power of two of main clock periods
`define RESET_SETTLE_LOG2 15
// external reset least low time, in ns, and in cycles at 4 ns (rounded up)
`define EXT_RESET_MIN_NS 10000
`define CLK_PERIOD_NS 4
`define EXT_RESET_MIN_CYC \
   ((`EXT_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// status register bits
`define ST_STOP 0
`define ST_SETTLE 1
`define ST_RUN 2
`define ST_PINS_HIZ 3
`define ST_WDT_CAUSE 4
`define ST_EXT_CAUSE 5

`endif

/* rtl/pin_sync.v */
`timescale 1ns/1ns
module pin_sync (
   // clock and reset
   input wire mclk,
   input wire rst,
   // pin and synchronised level
   input wire pin_in,
   output wire level_out
);
   reg meta_q;
   reg sync_q;

   // first flop is read by the second only
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
      end
   end

   assign level_out = sync_q;
endmodule

/* rtl/settle_counter.v */
`timescale 1ns/1ns
module settle_counter #(
   parameter WIDTH = 18
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // control
   input wire start,
   input wire [WIDTH-1:0] length,
   // status
   output reg busy,
   output reg done
);
   reg [WIDTH-1:0] cnt_q;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= {WIDTH{1'b0}};
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_q <= length;
            busy <= 1'b1;
         end else if (busy) begin
            if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

/* rtl/stop_release_and_reset_sequencer.v */
// What this block does
// [R1] unmasked request leaves stop; masked one stays
// [R2] enabled interrupts: vectored service after settle wait
// [R3] disabled interrupts: resume after stop instruction
// [R4] reset in stop: reset processing after settle
// [R5] pin low and watchdog overflow reset alike, except that only pin low clears subclock select
// [R6] program counter loaded from vector 0000h/0001h
// [R7] pins high impedance during reset and settle
// [R8] pin high releases, then 2^15 cycle settle
// [R9] watchdog reset self-releases, same settle wait
// [R10] external source holds pin low 10 us
// [R11] reset in stop holds stop contents, pins hiz
// [R12] only program counter undefined during reset, settle
// [R13] ram held when reset from standby
// [R14] subclock select cleared only by pin reset
// [R15] reset clears request flags, sets masks ff
// [R16] reset clears edge mode registers
// [R17] stop instruction enters stop
// [R18] stop settle length from settle select register
// [R19] pin synchronised, wait counted on main clock
// [R20] request seen without clock, restart oscillator first
`timescale 1ns/1ns
`include "reset_seq_defines.vh"
module stop_release_and_reset_sequencer #(
   parameter CNT_W = 18,
   parameter RESET_SETTLE = 32768,
   parameter EXT_MIN_CYC = `EXT_RESET_MIN_CYC
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // reset sources
   input wire ext_reset_n,
   input wire wdt_overflow,
   // cpu side
   input wire stop_exec,
   input wire [23:0] irq_raise,
   // vector fetch port
   output reg vec_rd_q,
   output reg [15:0] vec_addr_q,
   input wire [7:0] vec_data,
   // cpu control
   output reg cpu_run_q,
   output reg cpu_reset_q,
   output reg service_irq_q,
   output reg resume_next_q,
   output reg [15:0] program_counter_q,
   output reg pc_valid_q,
   // clock and pins
   output reg osc_enable_q,
   output reg pins_hiz_q,
   output reg ram_hold_q,
   // register port
   input wire [`ADDR_W-1:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata_q
);
   ////////////////////////////////////////////////////////////////////////
   localparam S_RESET = 7'b0000001;
   localparam S_SETTLE_RST = 7'b0000010;
   localparam S_VEC_LO = 7'b0000100;
   localparam S_VEC_HI = 7'b0001000;
   localparam S_RUN = 7'b0010000;
   localparam S_STOP = 7'b0100000;
   localparam S_SETTLE_STOP = 7'b1000000;

   reg [6:0] state_q;
   reg [7:0] irq_flag_q [0:2];
   reg [7:0] irq_mask_q [0:2];
   reg [7:0] edge_mode_a_q;
   reg [7:0] edge_mode_b_q;
   reg [7:0] subclock_select_q;
   reg [7:0] program_status_word_q;
   reg [7:0] osc_settle_time_select_q;
   reg wdt_cause_q;
   reg ext_cause_q;
   reg was_stop_q;
   reg [15:0] low_cnt_q;
   reg ext_low_q;
   reg settle_start;
   reg [CNT_W-1:0] settle_len;
   wire settle_busy;
   wire settle_done;
   wire ext_level;
   wire pend;
   integer i;

   ////////////////////////////////////////////////////////////////////////
   // pin synchroniser and settle counter
   pin_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .pin_in(ext_reset_n),
      .level_out(ext_level)
   ); // [R19]

   settle_counter #(.WIDTH(CNT_W)) u_settle (
      .mclk(mclk),
      .rst(rst),
      .start(settle_start),
      .length(settle_len),
      .busy(settle_busy),
      .done(settle_done)
   ); // [R19]

   // stop wait length in main clock periods per settle select code
   function [CNT_W-1:0] stop_len;
      input [2:0] sel;
      begin
         case (sel)
            3'd0: stop_len = 18'h01000;
            3'd2: stop_len = 18'h08000;
            3'd4: stop_len = 18'h10000;
            default: stop_len = 18'h04000;
         endcase
      end
   endfunction

   // any request whose mask bit is clear
   assign pend = |((({irq_flag_q[2], irq_flag_q[1], irq_flag_q[0]}
                   | irq_raise) &
                   ~{irq_mask_q[2], irq_mask_q[1], irq_mask_q[0]})); // [R1]

   ////////////////////////////////////////////////////////////////////////
   // pin low must last the least time to count as a reset
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_cnt_q <= 16'h0000;
         ext_low_q <= 1'b0;
      end else if (ext_level) begin
         low_cnt_q <= 16'h0000;
         ext_low_q <= 1'b0;
      end else if (low_cnt_q < EXT_MIN_CYC[15:0] - 16'h0001) begin
         low_cnt_q <= low_cnt_q + 16'h0001;
      end else begin
         ext_low_q <= 1'b1; // [R10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always @* begin
      settle_start = 1'b0;
      settle_len = RESET_SETTLE[CNT_W-1:0]; // [R8] [R9]
      if ((state_q == S_RESET) && !ext_low_q && !wdt_overflow) begin
         settle_start = 1'b1;
      end else if ((state_q == S_STOP) && pend) begin
         settle_start = 1'b1;
         settle_len = stop_len(osc_settle_time_select_q[2:0]); // [R18]
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= S_RESET;
         for (i = 0; i < 3; i = i + 1) begin
            irq_flag_q[i] <= `RST_IRQ_FLAG;
            irq_mask_q[i] <= `RST_IRQ_MASK;
         end
         edge_mode_a_q <= `RST_EDGE_MODE;
         edge_mode_b_q <= `RST_EDGE_MODE;
         subclock_select_q <= `RST_SUBCLK_SEL;
         program_status_word_q <= `RST_PSW;
         osc_settle_time_select_q <= `RST_OSC_SETTLE;
         wdt_cause_q <= 1'b0;
         ext_cause_q <= 1'b0;
         was_stop_q <= 1'b0;
         vec_rd_q <= 1'b0;
         vec_addr_q <= `VEC_LO_ADDR;
         cpu_run_q <= 1'b0;
         cpu_reset_q <= 1'b1;
         service_irq_q <= 1'b0;
         resume_next_q <= 1'b0;
         program_counter_q <= 16'h0000;
         pc_valid_q <= 1'b0;
         osc_enable_q <= 1'b1;
         pins_hiz_q <= 1'b1;
         ram_hold_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         vec_rd_q <= 1'b0;
         service_irq_q <= 1'b0;
         resume_next_q <= 1'b0;
         // hardware raised requests; set wins over a software write
         for (i = 0; i < 3; i = i + 1) begin
            if (wr && addr == `OFF_IRQ_FLAG0 + 8'h04 * i[7:0])
               irq_flag_q[i] <= wdata | irq_raise[8*i +: 8];
            else
               irq_flag_q[i] <= irq_flag_q[i] | irq_raise[8*i +: 8];
            if (wr && addr == `OFF_IRQ_MASK0 + 8'h04 * i[7:0])
               irq_mask_q[i] <= wdata;
         end
         if (wr && addr == `OFF_EDGE_MODE_A)
            edge_mode_a_q <= wdata;
         if (wr && addr == `OFF_EDGE_MODE_B)
            edge_mode_b_q <= wdata;
         if (wr && addr == `OFF_SUBCLK_SEL)
            subclock_select_q <= wdata;
         if (wr && addr == `OFF_PSW)
            program_status_word_q <= wdata;
         if (wr && addr == `OFF_OSC_SETTLE)
            osc_settle_time_select_q <= wdata;

         if ((ext_low_q || wdt_overflow) && state_q != S_RESET) begin
            // both sources give the same reset state, except that only pin reset clears subclock select
            state_q <= S_RESET; // [R5]
            cpu_run_q <= 1'b0;
            cpu_reset_q <= 1'b1;
            pc_valid_q <= 1'b0; // [R12]
            pins_hiz_q <= 1'b1; // [R7] [R11]
            was_stop_q <= (state_q == S_STOP) ||
                          (state_q == S_SETTLE_STOP);
            ram_hold_q <= (state_q == S_STOP) ||
                          (state_q == S_SETTLE_STOP); // [R13]
            wdt_cause_q <= wdt_overflow && !ext_low_q;
            ext_cause_q <= ext_low_q;
            if (ext_low_q)
               subclock_select_q <= `RST_SUBCLK_SEL; // [R14]
            for (i = 0; i < 3; i = i + 1) begin
               irq_flag_q[i] <= `RST_IRQ_FLAG; // [R15]
               irq_mask_q[i] <= `RST_IRQ_MASK; // [R15]
            end
            edge_mode_a_q <= `RST_EDGE_MODE; // [R16]
            edge_mode_b_q <= `RST_EDGE_MODE; // [R16]
            program_status_word_q <= `RST_PSW;
            osc_settle_time_select_q <= `RST_OSC_SETTLE;
         end else begin
            case (state_q)
               S_RESET: begin
                  // stop contents held while reset stands, oscillator off only if reset came in stop or stop settle
                  osc_enable_q <= !was_stop_q; // [R11]
                  if (settle_start) begin
                     osc_enable_q <= 1'b1;
                     state_q <= S_SETTLE_RST; // [R4] [R8] [R9]
                  end
               end
               S_SETTLE_RST: begin
                  if (settle_done) begin
                     state_q <= S_VEC_LO;
                     vec_rd_q <= 1'b1;
                     vec_addr_q <= `VEC_LO_ADDR; // [R6]
                  end
               end
               S_VEC_LO: begin
                  program_counter_q[7:0] <= vec_data;
                  vec_rd_q <= 1'b1;
                  vec_addr_q <= `VEC_HI_ADDR; // [R6]
                  state_q <= S_VEC_HI;
               end
               S_VEC_HI: begin
                  program_counter_q[15:8] <= vec_data; // [R6]
                  pc_valid_q <= 1'b1;
                  cpu_reset_q <= 1'b0;
                  cpu_run_q <= 1'b1;
                  pins_hiz_q <= 1'b0; // [R7]
                  ram_hold_q <= 1'b0;
                  was_stop_q <= 1'b0;
                  state_q <= S_RUN;
               end
               S_RUN: begin
                  if (stop_exec) begin
                     cpu_run_q <= 1'b0;
                     osc_enable_q <= 1'b0;
                     state_q <= S_STOP; // [R17]
                  end
               end
               S_STOP: begin
                  // request logic is combinational, needs no clock
                  if (settle_start) begin
                     osc_enable_q <= 1'b1; // [R20]
                     state_q <= S_SETTLE_STOP; // [R1]
                  end
               end
               S_SETTLE_STOP: begin
                  if (settle_done) begin
                     cpu_run_q <= 1'b1;
                     state_q <= S_RUN;
                     if (program_status_word_q[7])
                        service_irq_q <= 1'b1; // [R2]
                     else
                        resume_next_q <= 1'b1; // [R3]
                  end
               end
               default: state_q <= S_RESET;
            endcase
         end

         // read data, one cycle after the strobe
         rdata_q <= 8'h00;
         if (rd) begin
            case (addr)
               `OFF_IRQ_FLAG0: rdata_q <= irq_flag_q[0];
               `OFF_IRQ_FLAG1: rdata_q <= irq_flag_q[1];
               `OFF_IRQ_FLAG2: rdata_q <= irq_flag_q[2];
               `OFF_IRQ_MASK0: rdata_q <= irq_mask_q[0];
               `OFF_IRQ_MASK1: rdata_q <= irq_mask_q[1];
               `OFF_IRQ_MASK2: rdata_q <= irq_mask_q[2];
               `OFF_EDGE_MODE_A: rdata_q <= edge_mode_a_q;
               `OFF_EDGE_MODE_B: rdata_q <= edge_mode_b_q;
               `OFF_SUBCLK_SEL: rdata_q <= subclock_select_q;
               `OFF_PSW: rdata_q <= program_status_word_q;
               `OFF_OSC_SETTLE: rdata_q <= osc_settle_time_select_q;
               `OFF_STATUS: rdata_q <= {2'b00, ext_cause_q, wdt_cause_q,
                                        pins_hiz_q, cpu_run_q,
                                        settle_busy, state_q == S_STOP};
               `OFF_PC_LO: rdata_q <= program_counter_q[7:0];
               `OFF_PC_HI: rdata_q <= program_counter_q[15:8];
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end
endmodule

/* test/vector_rom.sv */
`timescale 1ns/1ns
module vector_rom #(
   parameter [7:0] VEC_LO = 8'h34,
   parameter [7:0] VEC_HI = 8'h12
) (
   // clock
   input wire mclk,
   // fetch
   input wire vec_rd_q,
   input wire [15:0] vec_addr_q,
   output wire [7:0] vec_data
);
   reg [7:0] junk_q = 8'h5a;
   // byte while the read strobe stands, junk otherwise
   always @(posedge mclk) begin
      junk_q <= junk_q + 8'h3b;
   end
   assign vec_data = !vec_rd_q ? ~junk_q :
                     (vec_addr_q[0] ? VEC_HI : VEC_LO);
endmodule

/* test/seq_chk.sv */
`timescale 1ns/1ns
module seq_chk #(
   parameter RESET_SETTLE = 32768
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // watched
   input wire ext_reset_n,
   input wire wdt_overflow,
   input wire stop_exec,
   input wire vec_rd_q,
   input wire [15:0] vec_addr_q,
   input wire cpu_run_q,
   input wire cpu_reset_q,
   input wire service_irq_q,
   input wire resume_next_q,
   input wire pc_valid_q,
   input wire osc_enable_q,
   input wire pins_hiz_q,
   input wire ram_hold_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   reg [17:0] quiet_q;
   // cycles with sources gone and pins still off
   always @(posedge mclk or posedge rst) begin
      if (rst)
         quiet_q <= 18'h0;
      else if (!ext_reset_n || wdt_overflow || !pins_hiz_q)
         quiet_q <= 18'h0;
      else if (quiet_q != 18'h3ffff)
         quiet_q <= quiet_q + 18'h1;
   end
   a_hiz_in_reset: assert property (
      cpu_reset_q |-> pins_hiz_q && !pc_valid_q)
      else $error("pins driven or pc valid in reset");
   a_wdt_resets: assert property (wdt_overflow |=> cpu_reset_q)
      else $error("watchdog overflow did not reset");
   a_settle_wait: assert property (
      vec_rd_q && vec_addr_q == 16'h0000 |-> quiet_q >= RESET_SETTLE)
      else $error("vector fetch before settle wait");
   a_vec_pair: assert property (
      vec_rd_q && vec_addr_q == 16'h0000
      |=> ##[0:1] vec_rd_q && vec_addr_q == 16'h0001)
      else $error("second vector byte missing");
   a_run_after_vec: assert property (
      vec_rd_q && vec_addr_q == 16'h0001
      |-> ##[1:3] cpu_run_q && pc_valid_q && !pins_hiz_q)
      else $error("no run after vector fetch");
   a_stop_entry: assert property (
      stop_exec && cpu_run_q && !wdt_overflow
      |=> !cpu_run_q && !osc_enable_q)
      else $error("stop not entered");
   a_one_outcome: assert property (
      service_irq_q || resume_next_q
      |-> cpu_run_q && osc_enable_q && !(service_irq_q && resume_next_q)
      ##1 !service_irq_q && !resume_next_q)
      else $error("bad stop exit outcome");
   a_ram_hold: assert property (ram_hold_q |-> pins_hiz_q)
      else $error("ram hold without high impedance");
   a_run_drives: assert property (
      cpu_run_q |-> !pins_hiz_q && pc_valid_q && !cpu_reset_q)
      else $error("running with pins off or pc undefined");
   a_osc_first: assert property ($rose(cpu_run_q) |-> osc_enable_q)
      else $error("run without oscillator");
   c_service: cover property (service_irq_q);
   c_resume: cover property (resume_next_q);
   c_stop_reset: cover property (ram_hold_q);
endmodule
bind stop_release_and_reset_sequencer seq_chk #(
   .RESET_SETTLE(RESET_SETTLE)
) chk_u (
   .mclk, .rst, .ext_reset_n, .wdt_overflow, .stop_exec, .vec_rd_q,
   .vec_addr_q, .cpu_run_q, .cpu_reset_q, .service_irq_q, .resume_next_q,
   .pc_valid_q, .osc_enable_q, .pins_hiz_q, .ram_hold_q
);

/* test/stop_release_and_reset_sequencer_test.sv */
`timescale 1ns/1ns
`include "reset_seq_defines.vh"
module stop_release_and_reset_sequencer_test;
   reg mclk = 0, rst = 1, ext_reset_n = 1, wdt_overflow = 0, stop_exec = 0;
   reg [23:0] irq_raise = 0;
   reg [7:0] addr = 0, wdata = 0, r;
   reg wr = 0, rd = 0, rd_d = 0;
   wire [7:0] vec_data, rdata_q;
   wire [15:0] vec_addr_q, program_counter_q;
   wire vec_rd_q, cpu_run_q, cpu_reset_q, service_irq_q, resume_next_q;
   wire pc_valid_q, osc_enable_q, pins_hiz_q, ram_hold_q;
   reg [7:0] exp_q[$];
   integer fail_count = 0, n_compared = 0, k, cyc;
   reg [31:0] seed = 33567;
   initial forever #2 mclk = ~mclk;
   stop_release_and_reset_sequencer #(.RESET_SETTLE(16), .EXT_MIN_CYC(4))
   dut_u (.mclk(mclk), .rst(rst), .ext_reset_n(ext_reset_n),
      .wdt_overflow(wdt_overflow), .stop_exec(stop_exec),
      .irq_raise(irq_raise), .vec_rd_q(vec_rd_q), .vec_addr_q(vec_addr_q),
      .vec_data(vec_data), .cpu_run_q(cpu_run_q), .cpu_reset_q(cpu_reset_q),
      .service_irq_q(service_irq_q), .resume_next_q(resume_next_q),
      .program_counter_q(program_counter_q), .pc_valid_q(pc_valid_q),
      .osc_enable_q(osc_enable_q), .pins_hiz_q(pins_hiz_q),
      .ram_hold_q(ram_hold_q), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata_q(rdata_q));
   vector_rom rom_u (.mclk(mclk), .vec_rd_q(vec_rd_q),
      .vec_addr_q(vec_addr_q), .vec_data(vec_data));
   function [7:0] rnd;
      input integer unused;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed[7:0];
      end
   endfunction
   task close_out;
      begin
         $display("compared %0d mismatches %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task check(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         @(posedge mclk);
         addr <= a;
         wdata <= d;
         wr <= 1;
         @(posedge mclk);
         wr <= 0;
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] e);
      begin
         @(posedge mclk);
         addr <= a;
         rd <= 1;
         exp_q.push_back(e);
         @(posedge mclk);
         rd <= 0;
      end
   endtask
   task pulse(input [1:0] w, input [23:0] irq);
      begin
         @(posedge mclk);
         stop_exec <= (w == 0);
         wdt_overflow <= (w == 1);
         irq_raise <= irq;
         @(posedge mclk);
         {stop_exec, wdt_overflow, irq_raise} <= 26'h0;
      end
   endtask
   task wait_run(input integer bound);
      begin
         #1;
         cyc = 0;
         while (cpu_run_q !== 1'b1 && cyc < bound) begin
            @(posedge mclk);
            #1 cyc = cyc + 1;
         end
         if (cyc == bound) begin
            fail_count = fail_count + 1;
            close_out;
         end
      end
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge mclk) begin
      if (rd_d && exp_q.size() > 0)
         check("rdata", rdata_q, exp_q.pop_front());
      rd_d <= rd;
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 0;
      wait_run(200);
      check("pc", program_counter_q, 16'h1234);
      rd_chk(`OFF_PC_LO, 8'h34);
      rd_chk(`OFF_STATUS, 8'h04);
      rd_chk(`OFF_IRQ_FLAG0, `RST_IRQ_FLAG);
      rd_chk(`OFF_IRQ_MASK2, `RST_IRQ_MASK);
      rd_chk(`OFF_EDGE_MODE_B, `RST_EDGE_MODE);
      rd_chk(`OFF_PSW, `RST_PSW);
      rd_chk(`OFF_OSC_SETTLE, `RST_OSC_SETTLE);
      rd_chk(8'h3c, 8'h00);
      r = rnd(0) | 8'h01;
      wr_reg(`OFF_SUBCLK_SEL, r);
      wr_reg(`OFF_EDGE_MODE_A, r);
      wr_reg(`OFF_IRQ_MASK1, 8'h00);
      pulse(1, 0);
      wait_run(200);
      rd_chk(`OFF_SUBCLK_SEL, r);
      rd_chk(`OFF_STATUS, 8'h14);
      rd_chk(`OFF_EDGE_MODE_A, 8'h00);
      rd_chk(`OFF_IRQ_MASK1, 8'hff);
      @(posedge mclk);
      ext_reset_n <= 0;
      repeat (8) @(posedge mclk);
      ext_reset_n <= 1;
      wait_run(200);
      rd_chk(`OFF_SUBCLK_SEL, 8'h00);
      for (k = 0; k < 2; k = k + 1) begin
         wr_reg(`OFF_IRQ_FLAG0, 8'h00);
         wr_reg(`OFF_IRQ_MASK0, 8'hfe);
         wr_reg(`OFF_OSC_SETTLE, 8'h00);
         wr_reg(`OFF_PSW, k ? 8'h00 : 8'h80);
         pulse(0, 0);
         #1 check("run", cpu_run_q, 1'b0);
         pulse(2, 24'h2 << (rnd(0) % 22));
         repeat (20) @(posedge mclk);
         #1 check("stop", cpu_run_q, 1'b0);
         pulse(2, 24'h1);
         cyc = 0;
         while ((service_irq_q | resume_next_q) !== 1'b1 && cyc < 6000) begin
            @(posedge mclk);
            #1 cyc = cyc + 1;
         end
         if (cyc == 6000) begin
            fail_count = fail_count + 1;
            close_out;
         end
         check("serve", service_irq_q, k ? 1'b0 : 1'b1);
         check("resume", resume_next_q, k ? 1'b1 : 1'b0);
         check("settle", cyc >= 4096, 1'b1);
      end
      wr_reg(`OFF_IRQ_FLAG0, 8'h00);
      pulse(0, 0);
      pulse(1, 0);
      #1 check("hold", ram_hold_q, 1'b1);
      check("osc", osc_enable_q, 1'b0);
      check("hiz", pins_hiz_q, 1'b1);
      wait_run(70000);
      repeat (3) @(posedge mclk);
      close_out;
   end
endmodule
